// file: verilog/psbp_top.sv
// Purpose: a/b signalling bit insert and extract for one pcm channel
// Assumes: strobes, shift clocks and selects are synchronous inputs
//          sampled on clk, far faster than any shift clock
// Notes:   pcm out is only driven for the eight bit periods of a word;
//          the highway pull-up holds the line while it is released
// Operation
// RQ1: rising rx select latches bit onto a
// RQ2: falling rx select latches bit onto b
// RQ3: use word of the frame select changed
// RQ4: send selected a/b in bit 8 next frame
// RQ5: tx select resynchronised to tx frame strobe
// RQ6: controller may share selects across channels
// RQ7: clock rate select sets divide ratio
// RQ8: controller supplies 8 khz locked strobes
// RQ9: controller keeps shift clocks within range
// RQ10: drive pcm out eight shift periods only
// RQ11: sample pcm in on falling rx shift
// RQ12: a/b outputs hold until matching transition
`timescale 1ns/100ps
`include "psbp_params.svh"
module psbp_top
  import psbp_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               master_clock,
  input  wire psbp_pkg::psbp_clksel_t clk_rate_sel,
  // transmit side
  input  wire logic               tx_strobe,
  input  wire logic               tx_shift,
  input  wire logic               tx_ab_sel,
  input  wire logic               sig_a_in,
  input  wire logic               sig_b_in,
  input  wire psbp_pkg::psbp_word_t tx_voice,
  output logic                    pcm_out_o,
  output logic                    pcm_out_oe,
  // receive side
  input  wire logic               rx_strobe,
  input  wire logic               rx_shift,
  input  wire logic               pcm_in,
  input  wire logic               rx_ab_sel,
  output logic                    sig_a_out,
  output logic                    sig_b_out,
  output psbp_pkg::psbp_word_t    rx_voice,
  output logic [7:0]              filt_div
);
  import psbp_pkg::*;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  // every detector stays quiet for one clk after reset
  logic tx_stb_r, tx_sh_r, tx_sh_f, rx_stb_r, rx_sh_r, rx_sh_f;
  logic rx_sel_r, rx_sel_f, mclk_r, mclk_f;
  psbp_edge u_txs  (.clk(clk), .nrst(nrst), .sig_in(tx_strobe),
                    .rise(tx_stb_r), .fall());
  psbp_edge u_txh  (.clk(clk), .nrst(nrst), .sig_in(tx_shift),
                    .rise(tx_sh_r), .fall(tx_sh_f));
  psbp_edge u_rxs  (.clk(clk), .nrst(nrst), .sig_in(rx_strobe),
                    .rise(rx_stb_r), .fall());
  psbp_edge u_rxh  (.clk(clk), .nrst(nrst), .sig_in(rx_shift),
                    .rise(rx_sh_r), .fall(rx_sh_f));
  psbp_edge u_rxsl (.clk(clk), .nrst(nrst), .sig_in(rx_ab_sel),
                    .rise(rx_sel_r), .fall(rx_sel_f));
  psbp_edge u_mclk (.clk(clk), .nrst(nrst), .sig_in(master_clock),
                    .rise(mclk_r), .fall(mclk_f));

  // ----------------------------------------------------------------
  // clock rate select
  // ----------------------------------------------------------------
  // divide ratio to the 256 khz filter clock; illegal code treated
  // as the 256 khz setting so the divider never stalls
  logic [7:0] div_sel;
  assign div_sel = (clk_rate_sel == `PSBP_CLKSEL_2048) ? `PSBP_DIV_2048 :
                   (clk_rate_sel == `PSBP_CLKSEL_1544) ? `PSBP_DIV_1544 :
                   `PSBP_DIV_256; // RQ7

  // registered so the pin comes straight from a flop
  logic [7:0] filt_div_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) filt_div_ff <= `PSBP_DIV_256;
    else       filt_div_ff <= div_sel; // RQ7
  end
  assign filt_div = filt_div_ff;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic       tx_sel_prev_ff, tx_sel_chg_ff, tx_sel_use_ff;
  logic [3:0] tx_cnt_ff;
  logic       tx_armed_ff, pcm_o_ff, pcm_oe_ff;
  psbp_word_t tx_word_ff;
  logic       tx_sel_chg, tx_sig_bit, tx_bit, tx_active;

  // a select edge in the strobe cycle counts for the next frame, so a
  // shared select never splits one word between the a and b inputs
  assign tx_sel_chg = tx_ab_sel ^ tx_sel_prev_ff;
  // selected input is sampled at the strobe that follows the change
  assign tx_sig_bit = tx_sel_use_ff ? sig_b_in : sig_a_in;
  assign tx_active  = (tx_cnt_ff != `PSBP_CNT_DONE);
  assign tx_bit     = tx_word_ff[3'(`PSBP_SIG_BIT_IDX - tx_cnt_ff)];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_sel_prev_ff <= 1'b0;
      tx_sel_chg_ff  <= 1'b0;
      tx_sel_use_ff  <= 1'b0;
    end else begin
      tx_sel_prev_ff <= tx_ab_sel;
      // change noted in this frame, applied at the next strobe
      if (tx_stb_r) begin
        tx_sel_chg_ff <= tx_sel_chg;
        if (tx_sel_chg_ff) tx_sel_use_ff <= tx_sel_prev_ff; // RQ5 RQ4
      end else if (tx_sel_chg) begin
        tx_sel_chg_ff <= 1'b1; // RQ5
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_ff   <= `PSBP_CNT_DONE;
      tx_armed_ff <= 1'b0;
      tx_word_ff  <= 8'h00;
      pcm_o_ff    <= 1'b0;
      pcm_oe_ff   <= 1'b0;
    end else begin
      if (tx_stb_r) begin
        tx_armed_ff <= 1'b1;
        tx_cnt_ff   <= 4'h0;
        // bit 8 carries the selected signalling input
        tx_word_ff  <= {tx_voice[7:1],
                        (tx_sel_chg_ff ? (tx_sel_prev_ff ? sig_b_in
                                                         : sig_a_in)
                                       : tx_sig_bit)}; // RQ4
      end else if (tx_sh_r && tx_armed_ff && tx_active) begin
        pcm_o_ff  <= tx_bit; // RQ10
        pcm_oe_ff <= 1'b1; // RQ10
        tx_cnt_ff <= 4'(tx_cnt_ff + 4'h1);
      // the ninth rise ends the eighth bit period and frees the line
      end else if (tx_sh_r && !tx_active) begin
        pcm_oe_ff   <= 1'b0; // RQ10
        tx_armed_ff <= 1'b0;
      end
    end
  end
  assign pcm_out_o  = pcm_o_ff;
  assign pcm_out_oe = pcm_oe_ff;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic [3:0] rx_cnt_ff;
  psbp_word_t rx_sr_ff, rx_voice_ff;
  logic       rx_done_ff, sig_a_ff, sig_b_ff;
  logic       rx_pend_a_ff, rx_pend_b_ff;
  logic       rx_last, rx_taking;

  // falls outside a word are ignored by the count; the finished word is
  // kept so a select edge after bit 8 still finds this frame's bit
  assign rx_taking = rx_sh_f && (rx_cnt_ff != `PSBP_CNT_DONE);
  assign rx_last   = rx_taking && (rx_cnt_ff == `PSBP_SIG_BIT_IDX);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_ff   <= `PSBP_CNT_DONE;
      rx_sr_ff    <= 8'h00;
      rx_voice_ff <= 8'h00;
      rx_done_ff  <= 1'b0;
    end else begin
      if (rx_stb_r) begin
        rx_cnt_ff  <= 4'h0;
        rx_done_ff <= 1'b0;
      end else if (rx_taking) begin
        rx_sr_ff  <= {rx_sr_ff[6:0], pcm_in}; // RQ11
        rx_cnt_ff <= 4'(rx_cnt_ff + 4'h1);
        if (rx_last) begin
          rx_voice_ff <= {rx_sr_ff[6:0], pcm_in};
          rx_done_ff  <= 1'b1;
        end
      end
    end
  end
  assign rx_voice = rx_voice_ff;

  // select edge in a frame is applied to that frame's bit 8, whether
  // the edge comes before or after the word is complete
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_pend_a_ff <= 1'b0;
      rx_pend_b_ff <= 1'b0;
      sig_a_ff     <= 1'b0;
      sig_b_ff     <= 1'b0;
    end else begin
      if (rx_stb_r) begin
        rx_pend_a_ff <= rx_sel_r;
        rx_pend_b_ff <= rx_sel_f;
      end else begin
        if (rx_sel_r && rx_done_ff) sig_a_ff <= rx_voice_ff[0]; // RQ1 RQ3
        if (rx_sel_f && rx_done_ff) sig_b_ff <= rx_voice_ff[0]; // RQ2 RQ3
        if (rx_sel_r && !rx_done_ff) rx_pend_a_ff <= 1'b1;
        if (rx_sel_f && !rx_done_ff) rx_pend_b_ff <= 1'b1;
        if (rx_last && (rx_pend_a_ff || rx_sel_r)) begin
          sig_a_ff     <= pcm_in; // RQ1 RQ3 RQ12
          rx_pend_a_ff <= 1'b0;
        end
        if (rx_last && (rx_pend_b_ff || rx_sel_f)) begin
          sig_b_ff     <= pcm_in; // RQ2 RQ3 RQ12
          rx_pend_b_ff <= 1'b0;
        end
      end
    end
  end
  assign sig_a_out = sig_a_ff;
  assign sig_b_out = sig_b_ff;

  // master clock edges are observed only; filter timing is outside
  logic unused_mclk;
  assign unused_mclk = mclk_r ^ mclk_f ^ tx_sh_f;
endmodule : psbp_top

// file: verilog/psbp_params.svh
// Purpose: constants for the pcm signalling bit path
// Assumes: included by bare name
// Notes:   word is msb first, bit 8 is the last bit shifted
`ifndef PSBP_PARAMS_SVH
`define PSBP_PARAMS_SVH
`define PSBP_WORD_BITS    4'h8
`define PSBP_SIG_BIT_IDX  4'h7
`define PSBP_CNT_DONE     4'h8
`define PSBP_CLKSEL_2048  2'h2
`define PSBP_CLKSEL_256   2'h0
`define PSBP_CLKSEL_1544  2'h1
`define PSBP_DIV_2048     8'h08
`define PSBP_DIV_256      8'h01
`define PSBP_DIV_1544     8'h06
`endif

// file: verilog/psbp_pkg.sv
// Purpose: types for the pcm signalling bit path
// Assumes: nothing
// Notes:   clock rate select is coded from the three-level pin
package psbp_pkg;
  typedef logic [1:0] psbp_clksel_t;
  typedef logic [7:0] psbp_word_t;
endpackage : psbp_pkg

// file: verilog/psbp_edge.sv
// Purpose: rising and falling edge detector on a synchronous input
// Assumes: input already synchronous to clk
// Notes:   pulses last one clk cycle
`timescale 1ns/100ps
module psbp_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // signal
  input  wire logic sig_in,
  output logic      rise,
  output logic      fall
);
  logic prev_ff;
  logic primed_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff   <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      prev_ff   <= sig_in;
      primed_ff <= 1'b1;
    end
  end

  // no edge until one real sample is held, so a pin that idles high
  // through reset does not look like a rising edge
  assign rise = primed_ff & sig_in & ~prev_ff;
  assign fall = primed_ff & ~sig_in & prev_ff;
endmodule : psbp_edge

// file: tb/psbp_checker.sv
// Purpose: port assertions for psbp_top
// Assumes: tx_voice holds steady through each frame
// Notes: pcm outputs move one clk after tx_shift is sampled high, rx_voice after rx_shift is sampled low
`timescale 1ns/100ps
module psbp_checker
  import psbp_pkg::*;
(
  // clock and reset
  input wire logic clk, nrst,
  // watched ports
  input wire psbp_pkg::psbp_clksel_t clk_rate_sel,
  input wire psbp_pkg::psbp_word_t   tx_voice, rx_voice,
  input wire logic [7:0]             filt_div,
  input wire logic tx_shift, pcm_out_o, pcm_out_oe, rx_shift,
  input wire logic rx_ab_sel, sig_a_out, sig_b_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_div_ratio: assert property (nrst && $stable(clk_rate_sel) |=>
    filt_div == ($past(clk_rate_sel) == 2'h2 ? 8'h08 :
                 $past(clk_rate_sel) == 2'h1 ? 8'h06 : 8'h01))
    else $error("divide ratio does not follow rate select");
  a_out_paced: assert property (
    !($past(tx_shift) && !$past(tx_shift, 2))
    |-> $stable({pcm_out_o, pcm_out_oe})) else $error("pcm out moved");
  a_oe_first: assert property (
    $rose(pcm_out_oe) |-> pcm_out_o == tx_voice[7])
    else $error("first bit is not the voice msb");
  a_a_hold: assert property ((!rx_ab_sel) [*4] |=> $stable(sig_a_out))
    else $error("a output moved while select low");
  a_b_hold: assert property (rx_ab_sel [*4] |=> $stable(sig_b_out))
    else $error("b output moved while select high");
  a_a_bit: assert property (
    $changed(sig_a_out) |-> ##[0:2] sig_a_out == rx_voice[0])
    else $error("a output not from received word");
  a_b_bit: assert property (
    $changed(sig_b_out) |-> ##[0:2] sig_b_out == rx_voice[0])
    else $error("b output not from received word");
  a_rx_on_fall: assert property ($changed(rx_voice) |-> !$past(rx_shift))
    else $error("rx word taken without a shift fall");
endmodule : psbp_checker
bind psbp_top psbp_checker chk_u (.clk(clk), .nrst(nrst),
  .clk_rate_sel(clk_rate_sel), .tx_voice(tx_voice), .rx_voice(rx_voice),
  .filt_div(filt_div), .tx_shift(tx_shift), .pcm_out_o(pcm_out_o),
  .pcm_out_oe(pcm_out_oe), .rx_shift(rx_shift), .rx_ab_sel(rx_ab_sel),
  .sig_a_out(sig_a_out), .sig_b_out(sig_b_out));

// file: tb/psbp_ctrl_model.sv
// Purpose: pcm highway controller driving one channel
// Assumes: one strobe and one shift feed both directions
// Notes: shift stands low between frames
`timescale 1ns/100ps
module psbp_ctrl_model
  import psbp_pkg::*;
(
  // clock
  input  wire logic clk,
  // towards the channel
  output logic      strobe, shift, pcm_in,
  // from the channel
  input  wire logic pcm_out_o, pcm_out_oe
);
  psbp_word_t got;
  int         oe_cnt;
  initial begin
    strobe = 1'b0;
    shift  = 1'b0;
    pcm_in = 1'b0;
  end
  // a ninth rise closes the word; per sets the shift half period
  task automatic frame(input psbp_word_t w, input int per);
    @(posedge clk) strobe <= 1'b1;
    repeat (2) @(posedge clk);
    strobe <= 1'b0;
    oe_cnt = 0;
    for (int i = 0; i < 9; i++) begin
      shift  <= 1'b1;
      pcm_in <= (i < 8) ? w[7 - i] : ~w[0];
      repeat (per) @(posedge clk);
      shift <= 1'b0;
      repeat (per) @(posedge clk);
      oe_cnt += pcm_out_oe;
      if (i < 8) got = {got[6:0], pcm_out_oe ? pcm_out_o : 1'b1};
    end
  endtask : frame
endmodule : psbp_ctrl_model

// file: tb/tb_top.sv
// Purpose: self-checking bench for psbp_top
// Assumes: one controller model feeds both directions
// Notes: a released pcm out reads high through its pull-up
`timescale 1ns/100ps
module tb_top;
  import psbp_pkg::*;
  logic         clk, nrst, strobe, shift, pcm_in;
  logic         master_clock = 1'b0;
  logic         tx_ab_sel, sig_a_in, sig_b_in, rx_ab_sel;
  logic         pcm_out_o, pcm_out_oe, sig_a_out, sig_b_out;
  psbp_clksel_t clk_rate_sel;
  psbp_word_t   tx_voice, rx_voice;
  logic [7:0]   filt_div;
  int           mismatches = 0, cmp_count = 0, cyc = 0;
  // shared strobe and shift, as a multiplex would wire them
  psbp_top dut_u (.clk(clk), .nrst(nrst), .master_clock(master_clock),
    .clk_rate_sel(clk_rate_sel), .tx_strobe(strobe), .tx_shift(shift),
    .tx_ab_sel(tx_ab_sel), .sig_a_in(sig_a_in), .sig_b_in(sig_b_in),
    .tx_voice(tx_voice), .pcm_out_o(pcm_out_o), .pcm_out_oe(pcm_out_oe),
    .rx_strobe(strobe), .rx_shift(shift), .pcm_in(pcm_in),
    .rx_ab_sel(rx_ab_sel), .sig_a_out(sig_a_out), .sig_b_out(sig_b_out),
    .rx_voice(rx_voice), .filt_div(filt_div));
  psbp_ctrl_model ctl_u (.clk(clk), .strobe(strobe), .shift(shift),
    .pcm_in(pcm_in), .pcm_out_o(pcm_out_o), .pcm_out_oe(pcm_out_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    master_clock <= ~master_clock;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      $display("unexpected at %0t: run timed out", $time);
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic sel_at(input int n, input logic v);
    repeat (n) @(posedge clk);
    rx_ab_sel <= v;
  endtask : sel_at
  task automatic t_rate();
    psbp_word_t exp [4] = '{8'h01, 8'h06, 8'h08, 8'h01};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) clk_rate_sel <= s[1:0];
      repeat (3) @(negedge clk);
      chk(filt_div, exp[s], "divide ratio");
    end
  endtask : t_rate
  task automatic t_tx();
    @(posedge clk) tx_voice <= 8'hA4;
    fork
      ctl_u.frame(8'h00, 3);
      begin
        repeat (12) @(posedge clk);
        tx_ab_sel <= 1'b1;
      end
    join
    chk(ctl_u.got, 8'hA5, "word with a bit");
    chk(ctl_u.oe_cnt[7:0], 8'h08, "driven bits");
    @(posedge clk) tx_voice <= 8'h3B;
    ctl_u.frame(8'h00, 3);
    chk(ctl_u.got, 8'h3A, "word with b bit");
  endtask : t_tx
  task automatic t_rx();
    fork
      ctl_u.frame(8'h35, 3);
      sel_at(12, 1'b1);
    join
    repeat (4) @(negedge clk);
    chk({6'h00, sig_a_out, sig_b_out}, 8'h02, "a on rise");
    chk(rx_voice, 8'h35, "rx word");
    sel_at(1, 1'b0);
    repeat (4) @(negedge clk);
    chk({6'h00, sig_a_out, sig_b_out}, 8'h03, "b on fall");
    ctl_u.frame(8'hCA, 3);
    repeat (4) @(negedge clk);
    chk({6'h00, sig_a_out, sig_b_out}, 8'h03, "a and b held");
    fork
      ctl_u.frame(8'h5C, 6);
      sel_at(30, 1'b1);
    join
    repeat (4) @(negedge clk);
    chk({6'h00, sig_a_out, sig_b_out}, 8'h01, "a on slow frame");
  endtask : t_rx
  initial begin
    nrst = 1'b0;
    clk_rate_sel = 2'h2;
    {tx_ab_sel, sig_a_in, sig_b_in, rx_ab_sel} = 4'h4;
    tx_voice = 8'h00;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_rate();
    t_tx();
    t_rx();
    conclude();
  end
endmodule : tb_top
